// ==== include/ts_sample_pkg.sv ====
// Constants and carriers for the event timestamp sample register block.
// Assumes one 10 MHz bus clock; the PTP time arrives on that same clock.
package ts_sample_pkg;

  localparam int          CLK_PERIOD_NS = 100;
  localparam int          SYNC_STAGES   = 3;
  localparam int          NUM_UNITS     = 2;
  localparam int          SAMPLE_DEPTH  = 3;
  localparam int          DEC_BITS      = 12;

  // Byte offsets of the sample registers
  localparam logic [11:0] OFS_S2_NS     = 12'h560;
  localparam logic [11:0] OFS_S2_SEC    = 12'h564;
  localparam logic [11:0] OFS_S2_SLOT   = 12'h568;
  localparam logic [11:0] OFS_S3_NS     = 12'h56c;
  localparam logic [11:0] OFS_S3_SEC    = 12'h570;
  localparam logic [11:0] OFS_S3_SLOT   = 12'h574;
  // Unit index and per-unit control
  localparam logic [11:0] OFS_UNIT_IDX  = 12'h400;
  localparam logic [11:0] OFS_UNIT_CTRL = 12'h550;

  // Field positions
  localparam int          POS_EDGE      = 30;
  localparam int          POS_UNIT_PTR  = 8;
  localparam int          POS_RISE_ON   = 7;
  localparam int          POS_FALL_ON   = 6;
  localparam int          POS_REARM     = 4;
  localparam int          POS_COUNT     = 0;

  // Values after reset
  localparam logic [29:0] NS_RESET      = 30'h00000000;
  localparam logic [31:0] SEC_RESET     = 32'h00000000;
  localparam logic [2:0]  SLOT_RESET    = 3'h0;
  localparam logic [31:0] RDATA_RESET   = 32'h00000000;

  // Slot codes for the five 8 ns slots of a 40 ns cycle
  localparam logic [2:0]  SLOT_0NS      = 3'h0;
  localparam logic [2:0]  SLOT_8NS      = 3'h1;
  localparam logic [2:0]  SLOT_16NS     = 3'h2;
  localparam logic [2:0]  SLOT_24NS     = 3'h3;
  localparam logic [2:0]  SLOT_32NS     = 3'h4;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
    logic [2:0]  slot_idx;
  } ptp_time_t;

  typedef struct packed {
    logic        edge_rise;
    logic [29:0] ns;
    logic [31:0] sec;
    logic [2:0]  slot;
  } sample_t;

  typedef struct packed {
    logic rise_on;
    logic fall_on;
  } unit_ctrl_t;

  localparam sample_t SAMPLE_RESET = '{1'b0, NS_RESET, SEC_RESET, SLOT_RESET};

  function automatic logic [2:0] slot_code(input logic [2:0] idx);
    logic [2:0] code;
    code = SLOT_0NS;
    case (idx)
      3'h0:    code = SLOT_0NS;
      3'h1:    code = SLOT_8NS;
      3'h2:    code = SLOT_16NS;
      3'h3:    code = SLOT_24NS;
      3'h4:    code = SLOT_32NS;
      default: code = SLOT_0NS;
    endcase
    return code;
  endfunction : slot_code

endpackage : ts_sample_pkg

// ==== verilog/ts_capture_unit.sv ====
// One timestamp input unit: synchronises its event pin and keeps samples.
// Assumes ptp_time is stable logic on hclk; event_pin is asynchronous.
`timescale 1ns/1ps
module ts_capture_unit #(
  parameter int DEPTH = 3
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     event_pin,
  input  wire ts_sample_pkg::ptp_time_t ptp_time,
  input  wire ts_sample_pkg::unit_ctrl_t ctrl,
  input  wire logic                     rearm,
  output ts_sample_pkg::sample_t        second_capture,
  output ts_sample_pkg::sample_t        third_capture,
  output logic [1:0]                    capture_count
);
  import ts_sample_pkg::*;

  logic [SYNC_STAGES-1:0] sync_reg;
  logic                   level_reg;
  logic [1:0]             cnt_reg;
  sample_t                samp_reg [DEPTH];
  logic                   change;
  logic                   rise;
  logic                   accept;
  logic [1:0]             wr_idx;

  // Stage 0 feeds stage 1 only; stages 1 and 2 must agree before a change counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], event_pin};
    end
  end

  assign change = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg);
  assign rise   = sync_reg[2];
  // Only edge types software enabled become samples
  assign accept = change && ((rise && ctrl.rise_on) || (!rise && ctrl.fall_on))
                  && (rearm || (cnt_reg < 2'(DEPTH)));
  assign wr_idx = rearm ? 2'h0 : cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg <= 1'b0;
    end else if (change) begin
      level_reg <= sync_reg[2];
    end
  end

  // A capture in the rearm cycle lands in the first slot rather than being lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 2'h0;
    end else if (rearm) begin
      cnt_reg <= accept ? 2'h1 : 2'h0;
    end else if (accept) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        samp_reg[i] <= SAMPLE_RESET;
      end
    end else if (accept) begin
      samp_reg[wr_idx] <= '{rise, ptp_time.ns, ptp_time.sec,
                            slot_code(ptp_time.slot_idx)};
    end
  end

  assign second_capture = samp_reg[1];
  assign third_capture  = samp_reg[2];
  assign capture_count  = cnt_reg;

  a_edge_second: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h1) |=> second_capture.edge_rise == $past(rise))
    else $error("second sample edge polarity wrong");

  a_edge_third: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h2) |=> third_capture.edge_rise == $past(rise))
    else $error("third sample edge polarity wrong");

  a_ns_second_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(accept && wr_idx == 2'h1) |=> $stable(second_capture.ns))
    else $error("second sample nanoseconds changed without capture");

  a_ns_third_take: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h2) |=> third_capture.ns == $past(ptp_time.ns))
    else $error("third sample nanoseconds not taken");

  a_sec_second_take: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h1) |=> second_capture.sec == $past(ptp_time.sec))
    else $error("second sample seconds not taken");

  a_sec_third_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(accept && wr_idx == 2'h2) |=> $stable(third_capture.sec))
    else $error("third sample seconds changed without capture");

  a_slot_second: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h1) |=> second_capture.slot == slot_code($past(ptp_time.slot_idx)))
    else $error("second sample slot code wrong");

  a_slot_third: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && wr_idx == 2'h2) |=> third_capture.slot == slot_code($past(ptp_time.slot_idx)))
    else $error("third sample slot code wrong");

  a_pin_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sync_reg[2]) && sync_reg[1] && !level_reg |-> change)
    else $error("settled pin change not recognised");

endmodule : ts_capture_unit

// ==== verilog/ts_sample_regs.sv ====
// AHB-Lite slave exposing the second and third event samples of two units.
// Assumes a single AHB-Lite master, word transfers only, event pins asynchronous.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module ts_sample_regs #(
  parameter int NUM_UNIT = 2
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic [NUM_UNIT-1:0]      event_pin,
  input  wire ts_sample_pkg::ptp_time_t ptp_time
);
  import ts_sample_pkg::*;

  logic                  unit_ptr_reg;
  logic                  unit_ptr_next;
  unit_ctrl_t            ctrl_reg  [NUM_UNIT];
  unit_ctrl_t            ctrl_next [NUM_UNIT];
  logic [NUM_UNIT-1:0]   rearm;
  logic                  wr_pend_reg;
  logic [11:0]           wr_addr_reg;
  logic                  rd_pend_reg;
  logic [11:0]           rd_addr_reg;
  logic [31:0]           hrdata_reg;
  logic                  hreadyout_reg;
  logic                  hresp_reg;
  logic                  addr_ok;
  logic                  wr_now;
  logic [31:0]           rd_word;
  sample_t               cap2 [NUM_UNIT];
  sample_t               cap3 [NUM_UNIT];
  logic [1:0]            cnt  [NUM_UNIT];

  for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
    ts_capture_unit #(
      .DEPTH          (SAMPLE_DEPTH)
    ) u_cap (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .event_pin      (event_pin[u]),
      .ptp_time       (ptp_time),
      .ctrl           (ctrl_reg[u]),
      .rearm          (rearm[u]),
      .second_capture (cap2[u]),
      .third_capture  (cap3[u]),
      .capture_count  (cnt[u])
    );
  end

  assign addr_ok = hsel && hready && htrans[1];
  assign wr_now  = wr_pend_reg && hready;

  // Next values forward a write in its data phase, so a read right behind it sees it
  always_comb begin
    unit_ptr_next = unit_ptr_reg;
    rearm         = '0;
    for (int u = 0; u < NUM_UNIT; u++) begin
      ctrl_next[u] = ctrl_reg[u];
    end
    if (wr_now && wr_addr_reg == OFS_UNIT_IDX) begin
      unit_ptr_next = hwdata[POS_UNIT_PTR];
    end
    if (wr_now && wr_addr_reg == OFS_UNIT_CTRL) begin
      ctrl_next[unit_ptr_reg].rise_on = hwdata[POS_RISE_ON];
      ctrl_next[unit_ptr_reg].fall_on = hwdata[POS_FALL_ON];
      rearm[unit_ptr_reg]             = hwdata[POS_REARM];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_ptr_reg <= 1'b0;
    end else begin
      unit_ptr_reg <= unit_ptr_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int u = 0; u < NUM_UNIT; u++) begin
        ctrl_reg[u] <= '0;
      end
    end else begin
      for (int u = 0; u < NUM_UNIT; u++) begin
        ctrl_reg[u] <= ctrl_next[u];
      end
    end
  end

  // Writes to the sample offsets match no write decode above and change nothing
  always_comb begin
    rd_word = '0;
    case (haddr[DEC_BITS-1:0])
      OFS_S2_NS: begin
        rd_word[POS_EDGE]   = cap2[unit_ptr_next].edge_rise;
        rd_word[29:0]       = cap2[unit_ptr_next].ns;
      end
      OFS_S2_SEC: begin
        rd_word             = cap2[unit_ptr_next].sec;
      end
      OFS_S2_SLOT: begin
        rd_word[2:0]        = cap2[unit_ptr_next].slot;
      end
      OFS_S3_NS: begin
        rd_word[POS_EDGE]   = cap3[unit_ptr_next].edge_rise;
        rd_word[29:0]       = cap3[unit_ptr_next].ns;
      end
      OFS_S3_SEC: begin
        rd_word             = cap3[unit_ptr_next].sec;
      end
      OFS_S3_SLOT: begin
        rd_word[2:0]        = cap3[unit_ptr_next].slot;
      end
      OFS_UNIT_IDX: begin
        rd_word[POS_UNIT_PTR] = unit_ptr_next;
      end
      OFS_UNIT_CTRL: begin
        rd_word[POS_RISE_ON]  = ctrl_next[unit_ptr_next].rise_on;
        rd_word[POS_FALL_ON]  = ctrl_next[unit_ptr_next].fall_on;
        rd_word[1:0]          = cnt[unit_ptr_next];
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[DEC_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else begin
      rd_pend_reg <= addr_ok && !hwrite;
      rd_addr_reg <= haddr[DEC_BITS-1:0];
    end
  end

  // Zero wait states: the word is fetched at the address edge and held one data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= RDATA_RESET;
    end else if (addr_ok && !hwrite) begin
      hrdata_reg <= rd_word;
    end else begin
      hrdata_reg <= RDATA_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  a_ns_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_reg && (rd_addr_reg == OFS_S2_NS || rd_addr_reg == OFS_S3_NS)) |-> !hrdata[31])
    else $error("reserved bit 31 of nanoseconds word not zero");

  a_slot_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_reg && (rd_addr_reg == OFS_S2_SLOT || rd_addr_reg == OFS_S3_SLOT))
    |-> hrdata[31:3] == 29'h0)
    else $error("reserved slot bits not zero");

  a_unit_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S2_SEC && !wr_now)
    |=> hrdata == $past(cap2[unit_ptr_reg].sec))
    else $error("seconds word not from selected unit");

  a_sample_write_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && wr_addr_reg == OFS_S3_SEC) |=> $stable(unit_ptr_reg))
    else $error("write to sample register changed state");

  a_always_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == HRESP_OKAY)
    else $error("slave not ready with OKAY");

  a_s2_edge_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S2_NS)
    |=> hrdata[POS_EDGE] == $past(cap2[unit_ptr_next].edge_rise))
    else $error("second sample edge bit not shown");

  a_s2_ns_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S2_NS)
    |=> hrdata[29:0] == $past(cap2[unit_ptr_next].ns))
    else $error("second sample nanoseconds not shown");

  a_s3_edge_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S3_NS)
    |=> hrdata[POS_EDGE] == $past(cap3[unit_ptr_next].edge_rise))
    else $error("third sample edge bit not shown");

  a_s3_ns_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S3_NS)
    |=> hrdata[29:0] == $past(cap3[unit_ptr_next].ns))
    else $error("third sample nanoseconds not shown");

  a_s3_sec_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S3_SEC)
    |=> hrdata == $past(cap3[unit_ptr_next].sec))
    else $error("third sample seconds not shown");

  a_s2_slot_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S2_SLOT)
    |=> hrdata == {29'h0, $past(cap2[unit_ptr_next].slot)})
    else $error("second sample slot not shown");

  a_s3_slot_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S3_SLOT)
    |=> hrdata == {29'h0, $past(cap3[unit_ptr_next].slot)})
    else $error("third sample slot not shown");

  a_idx_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_UNIT_IDX)
    |=> hrdata == (32'($past(unit_ptr_next)) << POS_UNIT_PTR))
    else $error("unit pointer not shown");

  a_ptr_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && wr_addr_reg == OFS_UNIT_IDX) |=> unit_ptr_reg == $past(hwdata[POS_UNIT_PTR]))
    else $error("unit pointer not written");

  a_ptr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_now && wr_addr_reg == OFS_UNIT_IDX) |=> $stable(unit_ptr_reg))
    else $error("unit pointer changed without write");

  a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && wr_addr_reg == OFS_UNIT_CTRL)
    |=> ctrl_reg[$past(unit_ptr_reg)] == $past(hwdata[POS_RISE_ON:POS_FALL_ON]))
    else $error("edge enables not written");

  a_ctrl_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_now && wr_addr_reg == OFS_UNIT_CTRL) |=> $stable(ctrl_reg[0]))
    else $error("edge enables changed without write");

  a_ctrl_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_UNIT_CTRL)
    |=> hrdata[31:8] == 24'h0 && hrdata[5:2] == 4'h0)
    else $error("reserved control bits not zero");

  a_ctrl_count_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_UNIT_CTRL)
    |=> hrdata[1:0] == $past(cnt[unit_ptr_next]))
    else $error("capture count not shown");

  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[DEC_BITS-1:0] == OFS_S3_SLOT + 12'h4)
    |=> hrdata == RDATA_RESET)
    else $error("unmapped offset not read as zero");

  a_write_no_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && hwrite) |=> hrdata == RDATA_RESET)
    else $error("read data shown in a write data phase");

  a_idle_rdata_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_pend_reg |-> hrdata == RDATA_RESET)
    else $error("read data not zero outside a read");

  a_rearm_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (rearm != '0) |-> (wr_now && wr_addr_reg == OFS_UNIT_CTRL && hwdata[POS_REARM]))
    else $error("rearm without control write");

  a_rearm_count: assert property (@(posedge hclk) disable iff (!hresetn)
    rearm[0] |=> cnt[0] <= 2'h1)
    else $error("rearm left a stale count");

  a_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
    !rearm[0] |=> (cnt[0] == $past(cnt[0]) || cnt[0] == $past(cnt[0]) + 2'h1))
    else $error("capture count jumped");

endmodule : ts_sample_regs

// ==== tb/ts_event_source.sv ====
// Partner model: event pins of the two timestamp units and a running PTP time.
// Assumes the bench calls toggle() from one process at a time.
`timescale 1ns/1ps
module ts_event_source (
  input  wire logic                hclk,
  output logic [1:0]               event_pin,
  output ts_sample_pkg::ptp_time_t ptp_time
);
  import ts_sample_pkg::*;

  int unsigned tick = 0;

  initial event_pin = 2'h0;

  always @(posedge hclk) begin
    tick <= tick + 1;
  end

  // Time is a pure function of the cycle count, so the bench can predict any capture
  function automatic ptp_time_t time_at(input int unsigned t);
    ptp_time_t v;
    v.sec      = 32'h5a000000 + t;
    v.ns       = 30'(t * 7);
    v.slot_idx = 3'(t % 5);
    return v;
  endfunction : time_at

  assign ptp_time = time_at(tick);

  // A pin level changes only just after an edge; stamp is the cycle count after that edge
  task automatic toggle(input int u, output int unsigned stamp);
    @(posedge hclk);
    event_pin[u] <= ~event_pin[u];
    #1;
    stamp = tick;
  endtask : toggle
endmodule : ts_event_source

// ==== tb/test_event_timestamp_sample_regs.sv ====
// Self-checking bench for the timestamp sample registers over AHB-Lite.
// Assumes the partner model ts_event_source drives event pins and PTP time.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_event_timestamp_sample_regs;
  import ts_sample_pkg::*;

  typedef struct {
    int         unit;
    logic       rise;
    logic       fall;
    int         gap;
    int         ntog;
    logic [1:0] cnt;
  } row_t;

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h2;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [1:0]  event_pin;
  wire  ptp_time_t ptp_time;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  logic [31:0] exp_w [2][6];
  // Slot index to code; the 16 ns slot is read as 010
  logic [2:0]  code_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  row_t        rows [6] = '{'{0, 1, 0, 3, 6, 2'h3}, '{0, 0, 1, 4, 6, 2'h3},
                            '{1, 1, 1, 3, 7, 2'h3}, '{1, 0, 0, 3, 2, 2'h0},
                            '{1, 0, 1, 5, 4, 2'h2}, '{0, 1, 1, 6, 3, 2'h3}};

  always #50 hclk = ~hclk;

  ts_sample_regs #(.NUM_UNIT(2)) i_ts_sample_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .event_pin(event_pin), .ptp_time(ptp_time));

  ts_event_source i_ts_event_source (
    .hclk(hclk), .event_pin(event_pin), .ptp_time(ptp_time));

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    `CHK(hresp, HRESP_OKAY)
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask : rd

  task automatic check_unit(input int u);
    logic [31:0] d;
    wr(OFS_UNIT_IDX, 32'(u) << POS_UNIT_PTR);
    rd(OFS_UNIT_IDX, d);
    `CHK(d, 32'(u) << POS_UNIT_PTR)
    for (int k = 0; k < 6; k++) begin
      rd(OFS_S2_NS + 12'(4 * k), d);
      `CHK(d, exp_w[u][k])
    end
  endtask : check_unit

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int u = 0; u < 2; u++) for (int k = 0; k < 6; k++) exp_w[u][k] = 32'h0;
  endtask : do_reset

  task automatic run_row(input row_t r);
    logic [31:0] d;
    int unsigned st;
    logic        lvl;
    ptp_time_t   v;
    int          n;
    int          j;
    n = 0;
    wr(OFS_UNIT_IDX, 32'(r.unit) << POS_UNIT_PTR);
    wr(OFS_UNIT_CTRL, {24'h0, r.rise, r.fall, 1'b0, 1'b1, 4'h0});
    for (int i = 0; i < r.ntog; i++) begin
      lvl = ~event_pin[r.unit];
      i_ts_event_source.toggle(r.unit, st);
      if ((lvl && r.rise) || (!lvl && r.fall)) begin
        n++;
        if (n == 2 || n == 3) begin
          j = 3 * (n - 2);
          v = i_ts_event_source.time_at(st + 3);
          exp_w[r.unit][j]     = {1'b0, lvl, v.ns};
          exp_w[r.unit][j + 1] = v.sec;
          exp_w[r.unit][j + 2] = {29'h0, code_tab[v.slot_idx]};
        end
      end
      repeat (r.gap) @(posedge hclk);
    end
    // Three sync stages plus the capture edge must pass before a read
    repeat (6) @(posedge hclk);
    rd(OFS_UNIT_CTRL, d);
    `CHK(d, {24'h0, r.rise, r.fall, 4'h0, r.cnt})
    check_unit(r.unit);
  endtask : run_row

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    logic [31:0] d;
    do_reset();
    check_unit(0);
    check_unit(1);
    foreach (rows[i]) run_row(rows[i]);
    // Writes to every sample register must leave the captures alone
    wr(OFS_UNIT_IDX, 32'h0);
    for (int k = 0; k < 6; k++) wr(OFS_S2_NS + 12'(4 * k), 32'hffffffff);
    check_unit(0);
    rd(12'h578, d);
    `CHK(d, 32'h0)
    do_reset();
    // Mid-run reset must clear the pointer and the enables and count of unit 0
    rd(OFS_UNIT_IDX, d);
    `CHK(d, 32'h0)
    rd(OFS_UNIT_CTRL, d);
    `CHK(d, 32'h0)
    check_unit(1);
    check_unit(0);
    final_report();
  end

  initial begin
    #2000000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : test_event_timestamp_sample_regs
